// >>> core/tmb_touch_core.sv
// tmb_touch_core: operating modes, scan timing, button and wheel evaluation
// assumes configuration inputs are held steady by the serial host interface
// What this block does
// - three modes only: active, doze and sleep; active and doze each with its scan period
// - active mode scans all enabled inputs each short period
// - doze mode uses its own longer scan period
// - sleep mode stops all scanning
// - active and doze periods are separately configurable
// - inactivity timer moves active to doze; it can be disabled
// - in doze any button touch wakes to active without sequence
// - with sequence enabled, correct ordered touch-release series wakes
// - host mode command forces the mode
// - button turns on when ticks reach threshold plus hysteresis
// - button turns off when ticks fall below threshold minus hysteresis
// - wheel on while any member detects a finger
// - wheel position spans zero to configured maximum
// - position zero at lowest indexed member, maximum at highest
// - position by centre of gravity of member ticks
// - rotation flagged only for change of at least step size
// - clockwise and counter-clockwise reported separately
// - inputs measured one at a time, disabled ones skipped
// - sensitivity set per input
// - sensitivity sets charge cycles per measurement
// - period is sensing, processing, then wait
// - button, wheel and rotation outputs update only in the processing phase; int_ack releases interrupt_out_n outside it
// - scan period from 15 ms upward beyond one second
`timescale 1ns/1ps
module tmb_touch_core #(
  parameter int MS_CYC = tmb_pkg::MS_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic [2*tmb_pkg::NUM_SENSE-1:0] role_cfg,
  input  wire logic [tmb_pkg::NUM_SENSE*tmb_pkg::SENS_W-1:0] sensitivity,
  input  wire logic [tmb_pkg::TICK_W-1:0] threshold,
  input  wire logic [tmb_pkg::TICK_W-1:0] hysteresis,
  input  wire logic [tmb_pkg::PERIOD_W-1:0] active_period_ms,
  input  wire logic [tmb_pkg::PERIOD_W-1:0] doze_period_ms,
  input  wire logic [7:0]                 passive_periods,
  input  wire logic                       passive_enable,
  input  wire logic                       wake_seq_enable,
  input  wire logic [4*tmb_pkg::SEQ_LEN-1:0] wake_seq,
  input  wire logic [tmb_pkg::POS_W-1:0]  pos_max,
  input  wire logic [tmb_pkg::POS_W-1:0]  rot_step,
  input  wire logic [1:0]                 mode_command_register,
  input  wire logic                       mode_cmd_write,
  input  wire logic                       int_ack,
  output logic      [3:0]                 conv_index,
  output logic      [7:0]                 conv_cycles,
  output logic                            conv_start,
  input  wire logic                       conv_done,
  input  wire logic [tmb_pkg::TICK_W-1:0] conv_ticks,
  output logic      [1:0]                 mode_state,
  output logic                            proc_phase,
  output logic      [tmb_pkg::NUM_SENSE-1:0] button_on,
  output logic                            wheel_on,
  output logic      [tmb_pkg::POS_W-1:0]  wheel_position,
  output logic                            rotate_cw,
  output logic                            rotate_ccw,
  output logic                            interrupt_out_n
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff, rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // roles
  // ----------------------------------------------------------------
  logic [tmb_pkg::NUM_SENSE-1:0] is_button, is_wheel, enabled;
  for (genvar g = 0; g < tmb_pkg::NUM_SENSE; g++) begin : g_role
    assign is_button[g] = role_cfg[2*g +: 2] == tmb_pkg::ROLE_BUTTON;
    assign is_wheel[g]  = role_cfg[2*g +: 2] == tmb_pkg::ROLE_WHEEL;
  end
  assign enabled = is_button | is_wheel;

  // ----------------------------------------------------------------
  // scan period timer
  // ----------------------------------------------------------------
  tmb_pkg::tmb_mode_t  mode_ff, nxt_mode;
  tmb_pkg::tmb_phase_t phase_ff, nxt_phase;
  logic [15:0] ms_cnt_ff;
  logic [11:0] per_cnt_ff;
  logic [11:0] sel_period, eff_period;
  logic        ms_tick, period_end, start_scan, sense_done, calc;

  assign sel_period = (mode_ff == tmb_pkg::MODE_DOZE) ? doze_period_ms
                                                      : active_period_ms;
  assign eff_period = (sel_period < 12'(tmb_pkg::MIN_PERIOD_MS))
                    ? 12'(tmb_pkg::MIN_PERIOD_MS) : sel_period;
  assign ms_tick    = ms_cnt_ff == 16'(MS_CYC - 1);
  assign period_end = ms_tick && (per_cnt_ff >= eff_period - 12'h1);
  assign start_scan = period_end && (mode_ff != tmb_pkg::MODE_SLEEP);
  assign calc       = phase_ff == tmb_pkg::PH_PROCESS;

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      tmb_pkg::PH_WAIT:    if (start_scan) nxt_phase = tmb_pkg::PH_SENSE;
      tmb_pkg::PH_SENSE:   if (sense_done) nxt_phase = tmb_pkg::PH_PROCESS;
      tmb_pkg::PH_PROCESS: nxt_phase = tmb_pkg::PH_WAIT;
      default:             nxt_phase = tmb_pkg::PH_WAIT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff  <= 16'h0;
      per_cnt_ff <= 12'h0;
      phase_ff   <= tmb_pkg::PH_WAIT;
    end else begin
      ms_cnt_ff  <= ms_tick ? 16'h0 : ms_cnt_ff + 16'h1;
      if (period_end) per_cnt_ff <= 12'h0;
      else if (ms_tick) per_cnt_ff <= per_cnt_ff + 12'h1;
      phase_ff   <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // measurement and tick store
  // ----------------------------------------------------------------
  logic                          tick_we;
  logic [3:0]                    tick_index;
  logic [tmb_pkg::TICK_W-1:0]    tick_data;
  logic [tmb_pkg::TICK_W-1:0]    ticks_ff [tmb_pkg::NUM_SENSE];
  logic [tmb_pkg::NUM_SENSE*tmb_pkg::TICK_W-1:0] ticks_flat;

  tmb_front_end u_fe (
    .clock       (clock),
    .rst_n       (rst_n),
    .start       (start_scan && phase_ff == tmb_pkg::PH_WAIT),
    .enable_mask (enabled),
    .sensitivity (sensitivity),
    .conv_index  (conv_index),
    .conv_cycles (conv_cycles),
    .conv_start  (conv_start),
    .conv_done   (conv_done),
    .conv_ticks  (conv_ticks),
    .tick_we     (tick_we),
    .tick_index  (tick_index),
    .tick_data   (tick_data),
    .sense_done  (sense_done)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tmb_pkg::NUM_SENSE; i++) ticks_ff[i] <= '0;
    end else if (tick_we) begin
      ticks_ff[tick_index] <= tick_data;
    end
  end

  for (genvar g = 0; g < tmb_pkg::NUM_SENSE; g++) begin : g_flat
    assign ticks_flat[g*tmb_pkg::TICK_W +: tmb_pkg::TICK_W] = ticks_ff[g];
  end

  // ----------------------------------------------------------------
  // button and wheel evaluation
  // ----------------------------------------------------------------
  logic [16:0] on_level, off_level;
  logic [tmb_pkg::NUM_SENSE-1:0] det_ff, nxt_det;
  logic [tmb_pkg::POS_W-1:0] new_pos;
  logic        nxt_wheel, nxt_cw, nxt_ccw, changed;
  logic [8:0]  diff_up, diff_dn;

  assign on_level  = 17'(threshold) + 17'(hysteresis);
  assign off_level = (hysteresis > threshold) ? 17'h0 : 17'(threshold - hysteresis);

  for (genvar g = 0; g < tmb_pkg::NUM_SENSE; g++) begin : g_det
    assign nxt_det[g] = !enabled[g] ? 1'b0
                      : det_ff[g] ? !(17'(ticks_ff[g]) < off_level)
                      : (17'(ticks_ff[g]) >= on_level);
  end
  assign nxt_wheel = |(nxt_det & is_wheel);

  tmb_wheel u_wheel (
    .clock    (clock),
    .rst_n    (rst_n),
    .calc     (calc && nxt_wheel),
    .member   (is_wheel),
    .ticks    (ticks_flat),
    .pos_max  (pos_max),
    .position (new_pos)
  );

  assign diff_up = 9'(new_pos) - 9'(wheel_position);
  assign diff_dn = 9'(wheel_position) - 9'(new_pos);
  // rotation judged one cycle after calc, once position settled
  assign nxt_cw  = wheel_on && (new_pos > wheel_position) &&
                   (diff_up >= 9'(rot_step)) && (rot_step != '0 || diff_up != 9'h0);
  assign nxt_ccw = wheel_on && (new_pos < wheel_position) &&
                   (diff_dn >= 9'(rot_step)) && (rot_step != '0 || diff_dn != 9'h0);

  logic post_ff;
  assign changed = (button_on != (det_ff & is_button)) || (wheel_on != (|(det_ff & is_wheel)))
                || (wheel_on && wheel_position != new_pos)
                || (rotate_cw != nxt_cw) || (rotate_ccw != nxt_ccw);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      det_ff          <= '0;
      post_ff         <= 1'b0;
      button_on       <= '0;
      wheel_on        <= 1'b0;
      wheel_position  <= '0;
      rotate_cw       <= 1'b0;
      rotate_ccw      <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      post_ff <= calc;
      if (calc) det_ff <= nxt_det;
      if (post_ff) begin
        button_on      <= det_ff & is_button;
        wheel_on       <= |(det_ff & is_wheel);
        rotate_cw      <= nxt_cw;
        rotate_ccw     <= nxt_ccw;
        if (|(det_ff & is_wheel)) wheel_position <= new_pos;
        if (changed) interrupt_out_n <= 1'b0;
      end else if (int_ack) begin
        interrupt_out_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  logic [7:0] idle_cnt_ff;
  logic [1:0] seq_pos_ff;
  logic [tmb_pkg::NUM_SENSE-1:0] prev_btn_ff;
  logic [3:0] want_idx;
  logic       any_touch, rel_ok, touch_bad, seq_done, idle_out;
  logic [tmb_pkg::NUM_SENSE-1:0] rel_edge, press_edge;

  assign any_touch  = |(det_ff & enabled);
  assign press_edge = (det_ff & is_button) & ~prev_btn_ff;
  assign rel_edge   = prev_btn_ff & ~(det_ff & is_button);
  assign want_idx   = wake_seq[4*seq_pos_ff +: 4];
  assign rel_ok     = rel_edge[want_idx] && (rel_edge == (12'h1 << want_idx));
  assign touch_bad  = |(press_edge & ~(12'h1 << want_idx));
  assign seq_done   = rel_ok && (seq_pos_ff == 2'(tmb_pkg::SEQ_LEN - 1));
  assign idle_out   = passive_enable && (idle_cnt_ff >= passive_periods);

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      tmb_pkg::MODE_ACTIVE: if (post_ff && idle_out) nxt_mode = tmb_pkg::MODE_DOZE;
      tmb_pkg::MODE_DOZE: begin
        if (post_ff && !wake_seq_enable && |(det_ff & is_button))
          nxt_mode = tmb_pkg::MODE_ACTIVE;
        else if (post_ff && wake_seq_enable && seq_done)
          nxt_mode = tmb_pkg::MODE_ACTIVE;
      end
      tmb_pkg::MODE_SLEEP: nxt_mode = tmb_pkg::MODE_SLEEP;
      default:             nxt_mode = tmb_pkg::MODE_ACTIVE;
    endcase
    if (mode_cmd_write) begin
      case (mode_command_register)
        tmb_pkg::CMD_ACTIVE: nxt_mode = tmb_pkg::MODE_ACTIVE;
        tmb_pkg::CMD_DOZE:   nxt_mode = tmb_pkg::MODE_DOZE;
        tmb_pkg::CMD_SLEEP:  nxt_mode = tmb_pkg::MODE_SLEEP;
        default:             nxt_mode = nxt_mode;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff     <= tmb_pkg::MODE_ACTIVE;
      idle_cnt_ff <= 8'h0;
      seq_pos_ff  <= 2'h0;
      prev_btn_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      if (post_ff) begin
        prev_btn_ff <= det_ff & is_button;
        if (any_touch || mode_ff != tmb_pkg::MODE_ACTIVE) idle_cnt_ff <= 8'h0;
        else if (idle_cnt_ff != 8'hff) idle_cnt_ff <= idle_cnt_ff + 8'h1;
        if (mode_ff != tmb_pkg::MODE_DOZE || touch_bad || seq_done) seq_pos_ff <= 2'h0;
        else if (rel_ok) seq_pos_ff <= seq_pos_ff + 2'h1;
      end
      if (nxt_mode != mode_ff) idle_cnt_ff <= 8'h0;
    end
  end

  assign mode_state = mode_ff;
  assign proc_phase = post_ff;
endmodule

// >>> include/tmb_pkg.sv
// tmb_pkg: constants and types of the touch mode, button and wheel logic
// assumes a 20 MHz system clock; every user including it writes tmb_pkg::name
package tmb_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          NUM_SENSE     = 12;
  localparam int          TICK_W        = 16;
  localparam int          POS_W         = 8;
  localparam int          SENS_W        = 3;
  localparam int          PERIOD_W      = 12;
  localparam int          SEQ_LEN       = 4;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 20000000;
  localparam int          MS_CYCLES     = CLK_HZ / 1000;
  localparam int          MIN_PERIOD_MS = 15;
  localparam logic [11:0] ACT_PERIOD_RST = 12'h01e;
  localparam logic [11:0] DOZE_PERIOD_RST = 12'h0c3;
  localparam int          BASE_CHARGE   = 4;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  ROLE_OFF      = 2'h0;
  localparam logic [1:0]  ROLE_BUTTON   = 2'h1;
  localparam logic [1:0]  ROLE_WHEEL    = 2'h2;
  localparam logic [1:0]  CMD_NONE      = 2'h0;
  localparam logic [1:0]  CMD_ACTIVE    = 2'h1;
  localparam logic [1:0]  CMD_DOZE      = 2'h2;
  localparam logic [1:0]  CMD_SLEEP     = 2'h3;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_DOZE, MODE_SLEEP} tmb_mode_t;
  typedef enum logic [1:0] {PH_SENSE, PH_PROCESS, PH_WAIT} tmb_phase_t;
endpackage

// >>> core/tmb_front_end.sv
// tmb_front_end: per-input measurement sequencer of the measurement_front_end
// assumes the analog converter returns ticks with a done pulse per conversion
`timescale 1ns/1ps
module tmb_front_end (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       start,
  input  wire logic [tmb_pkg::NUM_SENSE-1:0] enable_mask,
  input  wire logic [tmb_pkg::NUM_SENSE*tmb_pkg::SENS_W-1:0] sensitivity,
  output logic      [3:0]                 conv_index,
  output logic      [7:0]                 conv_cycles,
  output logic                            conv_start,
  input  wire logic                       conv_done,
  input  wire logic [tmb_pkg::TICK_W-1:0] conv_ticks,
  output logic                            tick_we,
  output logic      [3:0]                 tick_index,
  output logic      [tmb_pkg::TICK_W-1:0] tick_data,
  output logic                            sense_done
);
  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  logic       busy_ff, nxt_busy;
  logic       wait_ff;
  logic [3:0] idx_ff;
  logic [3:0] nxt_idx;
  logic       nxt_found;
  logic [2:0] cur_sens;
  logic       take;

  always_comb begin
    nxt_idx   = 4'h0;
    nxt_found = 1'b0;
    for (int i = tmb_pkg::NUM_SENSE - 1; i >= 0; i--) begin
      if (enable_mask[i] && (start ? 1'b1 : (i > int'(idx_ff)))) begin
        nxt_idx   = 4'(i);
        nxt_found = 1'b1;
      end
    end
  end

  assign cur_sens    = sensitivity[idx_ff*tmb_pkg::SENS_W +: tmb_pkg::SENS_W];
  assign conv_index  = idx_ff;
  assign conv_cycles = 8'(tmb_pkg::BASE_CHARGE) << cur_sens;
  assign conv_start  = busy_ff && !wait_ff;
  assign take        = conv_start && conv_done;
  assign nxt_busy    = start ? nxt_found : (busy_ff && !(take && !nxt_found));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff    <= 1'b0;
      wait_ff    <= 1'b0;
      idx_ff     <= 4'h0;
      tick_we    <= 1'b0;
      tick_index <= 4'h0;
      tick_data  <= '0;
      sense_done <= 1'b0;
    end else begin
      busy_ff    <= nxt_busy;
      tick_we    <= take;
      tick_index <= idx_ff;
      tick_data  <= conv_ticks;
      sense_done <= (start && !nxt_found) || (take && !nxt_found);
      if (start) begin
        idx_ff  <= nxt_idx;
        wait_ff <= 1'b0;
      end else if (take) begin
        idx_ff  <= nxt_idx;
        wait_ff <= 1'b1;
      end else begin
        wait_ff <= 1'b0;
      end
    end
  end
endmodule

// >>> core/tmb_wheel.sv
// tmb_wheel: centre of gravity position over the wheel members
// assumes ticks are stable while calc is high for one cycle
`timescale 1ns/1ps
module tmb_wheel (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       calc,
  input  wire logic [tmb_pkg::NUM_SENSE-1:0] member,
  input  wire logic [tmb_pkg::NUM_SENSE*tmb_pkg::TICK_W-1:0] ticks,
  input  wire logic [tmb_pkg::POS_W-1:0]  pos_max,
  output logic      [tmb_pkg::POS_W-1:0]  position
);
  // ----------------------------------------------------------------
  // weighting
  // ----------------------------------------------------------------
  logic [31:0] sum_w;
  logic [31:0] sum_t;
  logic [3:0]  rank;
  logic [3:0]  span;
  logic [31:0] cog;

  always_comb begin
    sum_w = 32'h0;
    sum_t = 32'h0;
    rank  = 4'h0;
    for (int i = 0; i < tmb_pkg::NUM_SENSE; i++) begin
      if (member[i]) begin
        sum_w = sum_w + 32'(ticks[i*tmb_pkg::TICK_W +: tmb_pkg::TICK_W]) * 32'(rank);
        sum_t = sum_t + 32'(ticks[i*tmb_pkg::TICK_W +: tmb_pkg::TICK_W]);
        rank  = rank + 4'h1;
      end
    end
    span = (rank > 4'h1) ? rank - 4'h1 : 4'h1;
    cog  = (sum_t == 32'h0) ? 32'h0
         : ((sum_w * 32'(pos_max)) / (sum_t * 32'(span)));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      position <= '0;
    end else if (calc) begin
      position <= (cog > 32'(pos_max)) ? pos_max : cog[tmb_pkg::POS_W-1:0];
    end
  end
endmodule

// >>> verification/tmb_touch_core_assertions.sv
// tmb_touch_core_assertions: port checker bound to tmb_touch_core
// assumes the raw rstn of the top module and one clock domain
`timescale 1ns/1ps
module tmb_touch_core_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [23:0] role_cfg,
  input wire logic [35:0] sensitivity,
  input wire logic [1:0]  mode_command_register,
  input wire logic        mode_cmd_write,
  input wire logic        int_ack,
  input wire logic [3:0]  conv_index,
  input wire logic [7:0]  conv_cycles,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [1:0]  mode_state,
  input wire logic        proc_phase,
  input wire logic [11:0] button_on,
  input wire logic        wheel_on,
  input wire logic [7:0]  wheel_position,
  input wire logic        rotate_cw,
  input wire logic        rotate_ccw,
  input wire logic        interrupt_out_n
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_conv_hold; conv_start && !conv_done |=> conv_start && $stable(conv_index);
  endproperty
  a_conv_hold: assert property (p_conv_hold) else $error("request dropped early");
  property p_conv_order; conv_start && conv_done |=> !conv_start
    ##1 (!conv_start || conv_index > $past(conv_index, 2)); endproperty
  a_conv_order: assert property (p_conv_order) else $error("input order wrong");
  property p_role; conv_start |-> role_cfg[2*conv_index +: 2] inside {2'h1, 2'h2}; endproperty
  a_role: assert property (p_role) else $error("disabled input measured");
  property p_cycles; conv_start && sensitivity[3*conv_index +: 3] < 3'h6
    |-> conv_cycles == (8'h04 << sensitivity[3*conv_index +: 3]); endproperty
  a_cycles: assert property (p_cycles) else $error("charge cycles wrong");
  property p_quiet; !$past(proc_phase)
    |-> $stable({button_on, wheel_on, wheel_position, rotate_cw, rotate_ccw}); endproperty
  a_quiet: assert property (p_quiet) else $error("output moved outside update");
  property p_int_set; $past(proc_phase)
    && !$stable({button_on, wheel_on, wheel_position, rotate_cw, rotate_ccw})
    |-> !interrupt_out_n; endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not raised");
  property p_int_hold; !interrupt_out_n && !int_ack |=> !interrupt_out_n; endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt lost");
  property p_cmd; mode_cmd_write && mode_command_register != 2'h0
    |=> mode_state == mode_command_register - 2'h1; endproperty
  a_cmd: assert property (p_cmd) else $error("mode command ignored");
  property p_sleep; mode_state == 2'h2 && !conv_start |=> !conv_start; endproperty
  a_sleep: assert property (p_sleep) else $error("scan in sleep");
  property p_rot; !(rotate_cw && rotate_ccw); endproperty
  a_rot: assert property (p_rot) else $error("both rotations set");
endmodule
bind tmb_touch_core tmb_touch_core_checker u_chk (.clock(clock), .rstn(rstn),
  .role_cfg(role_cfg), .sensitivity(sensitivity), .mode_command_register(mode_command_register),
  .mode_cmd_write(mode_cmd_write), .int_ack(int_ack), .conv_index(conv_index),
  .conv_cycles(conv_cycles), .conv_start(conv_start), .conv_done(conv_done),
  .mode_state(mode_state), .proc_phase(proc_phase), .button_on(button_on), .wheel_on(wheel_on),
  .wheel_position(wheel_position), .rotate_cw(rotate_cw), .rotate_ccw(rotate_ccw),
  .interrupt_out_n(interrupt_out_n));

// >>> verification/tmb_conv_model.sv
// tmb_conv_model: behavioural analog converter at the measurement_front_end
// assumes conv_start is held until conv_done
`timescale 1ns/1ps
module tmb_conv_model (
  input  wire logic         clock,
  input  wire logic [3:0]   conv_index,
  input  wire logic [7:0]   conv_cycles,
  input  wire logic         conv_start,
  input  wire logic [191:0] tick_tab,
  input  wire logic         slow,
  output logic              conv_done = 1'b0,
  output logic      [15:0]  conv_ticks = 16'h0000
);
  logic [3:0] wait_ff = 4'h0;
  always @(posedge clock) begin
    conv_done <= 1'b0;
    if (conv_done) conv_ticks <= ~conv_ticks;
    if (conv_start && !conv_done) begin
      if (wait_ff != 4'h0) wait_ff <= wait_ff - 4'h1;
      else begin
        conv_done  <= 1'b1;
        conv_ticks <= tick_tab[16*conv_index +: 16] * (conv_cycles >> 2);
        wait_ff    <= slow ? 4'h5 : 4'h0;
      end
    end
  end
endmodule

// >>> verification/tmb_touch_core_tb.sv
// tmb_touch_core_tb: self-checking bench of tmb_touch_core
// assumes tmb_conv_model stands for the analog converter
`timescale 1ns/1ps
module tmb_touch_core_tb;
  logic [191:0] tab = '0;
  logic clock = 1'b0, rstn = 1'b0, slow = 1'b0, wr = 1'b0, ack = 1'b0, pen = 1'b0, wen = 1'b0;
  logic [23:0] role = 24'h2aa555;
  logic [35:0] sens = 36'h000400040;
  logic [15:0] thr = 16'd100, hys = 16'd10;
  logic [11:0] aper = 12'h00f, dper = 12'h014;
  logic cs_q = 1'b0;
  logic [1:0] mcmd = 2'h0, mode_state;
  logic [3:0] ci;
  logic [7:0] cc, wheel_position;
  logic cs, cd, proc_phase, wheel_on, rotate_cw, rotate_ccw, interrupt_out_n;
  logic [11:0] button_on;
  logic [15:0] ct;
  int n_fail = 0, num_checks = 0, cyc = 0, won = 0, wpos = 0, nscan = 0;
  int ns0 = 0, gap = 0, t0 = 0;
  int bon[11] = '{default: 0};
  int bnd[5] = '{110, 91, 89, 109, 110};
  always #25 clock = ~clock;
  tmb_touch_core #(.MS_CYC(4)) dut (.clock(clock), .rstn(rstn), .role_cfg(role),
    .sensitivity(sens), .threshold(thr), .hysteresis(hys), .active_period_ms(aper),
    .doze_period_ms(dper), .passive_periods(8'h04), .passive_enable(pen),
    .wake_seq_enable(wen), .wake_seq(16'h4150), .pos_max(8'h40), .rot_step(8'h08),
    .mode_command_register(mcmd), .mode_cmd_write(wr), .int_ack(ack), .conv_index(ci),
    .conv_cycles(cc), .conv_start(cs), .conv_done(cd), .conv_ticks(ct),
    .mode_state(mode_state), .proc_phase(proc_phase), .button_on(button_on),
    .wheel_on(wheel_on), .wheel_position(wheel_position), .rotate_cw(rotate_cw),
    .rotate_ccw(rotate_ccw), .interrupt_out_n(interrupt_out_n));
  tmb_conv_model u_conv (.clock(clock), .conv_index(ci), .conv_cycles(cc), .conv_start(cs),
    .tick_tab(tab), .slow(slow), .conv_done(cd), .conv_ticks(ct));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // model of one scan period, compared at its update
  task automatic period();
    int t, sum, acc, hi, nw, np, chg, nb;
    logic [11:0] eb;
    sum = 0; acc = 0; hi = 0; chg = 0; eb = '0;
    for (int k = 0; k < 2000 && proc_phase !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    for (int i = 0; i < 11; i++) begin
      t = tab[16*i +: 16] << sens[3*i +: 3];
      nb = t >= thr + hys ? 1 : (t < thr - hys ? 0 : bon[i]);
      if (i < 6) begin
        chg |= nb != bon[i];
        eb[i] = nb[0];
      end else begin
        sum += t;
        acc += (i - 6) * t;
        hi |= nb;
      end
      bon[i] = nb;
    end
    nw = hi;
    np = sum ? acc * 64 / (sum * 4) : 0;
    chg |= nw != won;
    chk("buttons", button_on, eb);
    chk("wheel on", wheel_on, nw);
    if (nw) chk("wheel position", wheel_position, np);
    if (nw && won) chk("rotate cw", rotate_cw, np - wpos >= 8);
    if (nw && won) chk("rotate ccw", rotate_ccw, wpos - np >= 8);
    if (chg) chk("interrupt set", interrupt_out_n, 0);
    won = nw;
    wpos = np;
    ack = 1'b1;
    @(negedge clock);
    ack = 1'b0;
    chk("interrupt released", interrupt_out_n, 1);
  endtask
  task automatic cmd(input logic [1:0] c);
    @(negedge clock);
    mcmd = c;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    nscan <= nscan + int'(cs);
    cs_q <= cs;
    if (cs && !cs_q && ci == 4'h0) begin
      gap <= cyc - t0;
      t0 <= cyc;
    end
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(28643));
    repeat (20) @(negedge clock);
    rstn = 1'b1;
    repeat (3) @(negedge clock);
    chk("reset mode", mode_state, 0);
    chk("reset interrupt", interrupt_out_n, 1);
    foreach (bnd[j]) begin
      tab[15:0] = 16'(bnd[j]);
      period();
    end
    for (int r = 0; r < 25; r++) begin
      slow = r[0];
      for (int i = 0; i < 11; i++) tab[16*i +: 16] = 16'($urandom_range(0, 200));
      period();
    end
    tab = '0;
    repeat (6) period();
    chk("no doze with timer off", mode_state, 0);
    chk("active period", gap, aper * 4);
    pen = 1'b1;
    repeat (7) period();
    chk("doze after idle", mode_state, 1);
    chk("doze period", gap, dper * 4);
    tab[63:48] = 16'd150;
    repeat (2) period();
    chk("wake by touch", mode_state, 0);
    tab = '0;
    wen = 1'b1;
    repeat (7) period();
    tab[47:32] = 16'd150;
    period();
    tab = '0;
    period();
    chk("wrong key stays dozing", mode_state, 1);
    for (int j = 0; j < 4; j++) begin
      tab[16*(j == 0 ? 0 : j == 1 ? 5 : j == 2 ? 1 : 4) +: 16] = 16'd150;
      period();
      tab = '0;
      period();
    end
    chk("wake by sequence", mode_state, 0);
    pen = 1'b0;
    wen = 1'b0;
    for (int j = 0; j < 4; j++) begin
      cmd(2'(2 + j * 3));
      chk("mode after command", mode_state, j == 0 ? 1 : (j == 3 ? 2 : 0));
    end
    ns0 = nscan;
    repeat (300) @(negedge clock);
    chk("no scan in sleep", nscan - ns0, 0);
    cmd(2'h1);
    period();
    chk("active again", mode_state, 0);
    report_and_stop();
  end
endmodule
